// >>> dram_mode_config_burst_order.sv
// Purpose: Mode register decode and burst ordering for two mode registers
// Assumes: Pins are synchronous to ref_clk; one beat per clock
// Notes: Beat storage is an eight-entry flip-flop burst buffer
//
// Function
// - Column read latency from A2, A4-A6
// - Total read delay is added delay plus latency
// - A3 selects sequential or interleaved beat order
// - A0-A1 pick chop, eight, or on-the-fly
// - Sequential reads wrap within half, other half follows
// - Interleaved beat n is start column XOR n
// - Chopped reads: four beats, then drivers off
// - Writes ignore low column bits, fixed order
// - Fixed chop starts internal write two clocks early
// - Loop reset bit clears itself after reset
// - A12 zero freezes loop in precharge power-down
// - Loop off in self-refresh, back on exit
// - Driver impedance from A1 and A5
`timescale 1ns/10ps
`default_nettype none
module dram_mode_config_burst_order
    import mode_pkg::*;
#(
    parameter int DQ_W       = 16,
    parameter int LOCK_COUNT = mode_pkg::LOOP_LOCK_CYCLES
) (
    input  wire  logic                        ref_clk,
    input  wire  logic                        rst_n,
    input  wire  logic                        chip_select_n,
    input  wire  logic                        row_strobe_n,
    input  wire  logic                        column_strobe_n,
    input  wire  logic                        write_enable_n,
    input  wire  logic [2:0]                  bank_addr,
    input  wire  logic [mode_pkg::ADDR_W-1:0] addr,
    input  wire  logic [DQ_W-1:0]             dq_in,
    input  wire  logic                        self_refresh,
    input  wire  logic                        precharge_powerdown,
    output var   logic [DQ_W-1:0]             dq_out,
    output var   logic                        dq_oe,
    output var   logic                        strobe_oe,
    output logic [4:0]                        column_read_latency,
    output logic [4:0]                        total_read_delay,
    output logic                              test_mode,
    output logic [2:0]                        write_recovery,
    output logic [1:0]                        drive_strength,
    output logic                              loop_running,
    output logic                              loop_locking,
    output var   logic                        internal_write_start
);
    import mode_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_RD_WAIT, ST_RD_BURST, ST_WR_BURST} burst_state_t;

    logic [ADDR_W-1:0] operating_mode_register;
    logic [ADDR_W-1:0] loop_and_drive_register;
    burst_state_t      state;
    logic [4:0]        wait_cnt;
    logic [2:0]        slot;
    logic [2:0]        start_column_bits;
    logic              chop;
    logic              fixed_chop_burst;
    logic [DQ_W-1:0]   beat_mem [8];
    logic [$clog2(LOCK_COUNT+1)-1:0] lock_cnt;

    // Command decode
    wire cmd_sel   = !chip_select_n && !column_strobe_n;
    wire cmd_mrs   = cmd_sel && !row_strobe_n && !write_enable_n;
    wire cmd_read  = cmd_sel && row_strobe_n && write_enable_n;
    wire cmd_write = cmd_sel && row_strobe_n && !write_enable_n;
    wire wr_opm    = cmd_mrs && (bank_addr == BANK_OPERATING);
    wire wr_loop   = cmd_mrs && (bank_addr == BANK_LOOP);

    // Field views
    wire [3:0] cl_code = {operating_mode_register[OPM_CL_HI_HI:OPM_CL_HI_LO],
                          operating_mode_register[OPM_CL_LOW]};
    wire [1:0] bl_mode = operating_mode_register[OPM_BL_HI:OPM_BL_LO];
    wire       interleave = operating_mode_register[OPM_ORDER];
    wire [1:0] al_code = loop_and_drive_register[LD_AL_HI:LD_AL_LO];
    wire       outputs_off = loop_and_drive_register[LD_OUT_OFF];
    wire       loop_enabled = !loop_and_drive_register[LD_LOOP_OFF];

    // Latency: A2 chooses the code group, A4-A6 the step within it
    assign column_read_latency = (cl_code[0] ? CL_BASE_HIGH : CL_BASE_LOW)
                                 + {2'h0, cl_code[3:1]};
    wire [4:0] added_command_delay = (al_code == 2'h1) ? column_read_latency - 5'h01 :
                                     (al_code == 2'h2) ? column_read_latency - 5'h02 :
                                     5'h00;
    // Whole cycles only; no half-clock term exists in the sum
    assign total_read_delay = added_command_delay + column_read_latency;

    assign test_mode      = operating_mode_register[OPM_TEST];
    assign write_recovery = operating_mode_register[OPM_WR_HI:OPM_WR_LO];
    assign drive_strength = {loop_and_drive_register[LD_DRV_HI],
                             loop_and_drive_register[LD_DRV_LO]};

    // Burst length choice; on-the-fly samples the chop pin (A12 low = chop)
    wire cmd_chop  = (bl_mode == BL_FIXED_CHOP) ||
                     ((bl_mode == BL_ON_THE_FLY) && !addr[ADDR_W-1]);
    wire cmd_fixed = (bl_mode == BL_FIXED_CHOP);

    // Loop state: frozen in self-refresh and in slow-exit power-down
    assign loop_running = loop_enabled && !self_refresh &&
                          !(precharge_powerdown && !operating_mode_register[OPM_PD_FAST]);
    assign loop_locking = (lock_cnt != '0);

    // Burst sequencing
    wire       idle       = (state == ST_IDLE);
    wire       take_read  = idle && cmd_read;
    wire       take_write = idle && cmd_write;
    wire [2:0] burst_last = chop ? CHOP_LAST_SLOT : LAST_SLOT;
    wire       wait_done  = (state == ST_RD_WAIT) && (wait_cnt <= 5'h01);
    wire       burst_end  = ((state == ST_RD_BURST) || (state == ST_WR_BURST))
                            && (slot == LAST_SLOT);

    burst_state_t next_state;
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:     next_state = take_read ? ST_RD_WAIT :
                                      (take_write ? ST_WR_BURST : ST_IDLE);
            ST_RD_WAIT:  next_state = wait_done ? ST_RD_BURST : ST_RD_WAIT;
            ST_RD_BURST: next_state = burst_end ? ST_IDLE : ST_RD_BURST;
            ST_WR_BURST: next_state = burst_end ? ST_IDLE : ST_WR_BURST;
        endcase
    end

    wire [2:0] next_slot = (state == ST_RD_BURST || state == ST_WR_BURST)
                           ? slot + 3'h1 : 3'h0;

    // Read beat address for beat n of the coming cycle
    wire [2:0] seq_addr = {start_column_bits[2] ^ next_slot[2],
                           start_column_bits[1:0] + next_slot[1:0]};
    wire [2:0] ilv_addr = start_column_bits ^ next_slot;
    wire [2:0] rd_addr  = interleave ? ilv_addr : seq_addr;
    wire       next_rd  = (next_state == ST_RD_BURST);
    // Drivers stay off for the last four slots of a chop
    wire       next_drive = next_rd && !(chop && next_slot[2]) && !outputs_off;

    // Write beat address: low column bits ignored, chop picks half by bit two
    wire [2:0] wr_addr  = chop ? {start_column_bits[2], slot[1:0]} : slot;
    wire       wr_store = (state == ST_WR_BURST) && (!chop || slot <= burst_last);
    // Fixed chop pulls the internal write start in by two clocks
    wire [2:0] wr_start_slot = fixed_chop_burst ? WR_START_EIGHT - WR_PULL_IN
                                                : WR_START_EIGHT;

    // Mode registers; loop reset bit returns to zero the cycle after it is set
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            operating_mode_register <= OPM_RESET;
            loop_and_drive_register <= LD_RESET;
        end else begin
            if (wr_opm) begin
                operating_mode_register <= addr;
            end else if (operating_mode_register[OPM_LOOP_RST]) begin
                operating_mode_register[OPM_LOOP_RST] <= 1'b0;
            end
            if (wr_loop) begin
                loop_and_drive_register <= addr;
            end
        end
    end

    // Lock timer restarts on every loop reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_cnt <= '0;
        end else if (operating_mode_register[OPM_LOOP_RST]) begin
            lock_cnt <= ($clog2(LOCK_COUNT+1))'(LOCK_COUNT);
        end else if (lock_cnt != '0) begin
            lock_cnt <= lock_cnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state             <= ST_IDLE;
            slot              <= 3'h0;
            wait_cnt          <= 5'h00;
            start_column_bits <= 3'h0;
            chop              <= 1'b0;
            fixed_chop_burst  <= 1'b0;
        end else begin
            state <= next_state;
            slot  <= next_slot;
            if (take_read || take_write) begin
                start_column_bits <= addr[2:0];
                chop              <= cmd_chop;
                fixed_chop_burst  <= cmd_fixed;
                wait_cnt          <= total_read_delay - 5'h01;
            end else if (state == ST_RD_WAIT) begin
                wait_cnt <= wait_cnt - 5'h01;
            end
        end
    end

    // Output stage, aligned with the burst slot
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_out               <= '0;
            dq_oe                <= 1'b0;
            strobe_oe            <= 1'b0;
            internal_write_start <= 1'b0;
        end else begin
            dq_out               <= beat_mem[rd_addr];
            dq_oe                <= next_drive;
            strobe_oe            <= next_drive;
            internal_write_start <= (state == ST_WR_BURST) && (slot == wr_start_slot);
        end
    end

    // Burst buffer, one flip-flop row per beat
    for (genvar i = 0; i < 8; i++) begin : g_beat
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                beat_mem[i] <= '0;
            end else if (wr_store && (wr_addr == 3'(i))) begin
                beat_mem[i] <= dq_in;
            end
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_loop_reset_clears: assert property (
        operating_mode_register[OPM_LOOP_RST] |=> !operating_mode_register[OPM_LOOP_RST]
            || $past(wr_opm))
        else $error("loop reset bit did not clear");

    a_read_delay_sum: assert property (
        (al_code == 2'h0) |-> (total_read_delay == column_read_latency))
        else $error("read delay not equal to latency with no added delay");

    a_latency_decode: assert property (
        $rose(wr_opm) ##1 (cl_code == 4'h0) |-> (column_read_latency == CL_BASE_LOW))
        else $error("latency decode wrong");

    a_chop_tail_off: assert property (
        (state == ST_RD_BURST) && chop && slot[2] |-> !dq_oe && !strobe_oe)
        else $error("drivers active in chop tail");

    a_eight_read_drive: assert property (
        (state == ST_RD_BURST) && !chop && !outputs_off |-> dq_oe)
        else $error("eight beat read not driven");

    a_interleave_order: assert property (
        (state == ST_RD_BURST) && interleave && (slot != LAST_SLOT)
            |=> (state == ST_RD_BURST) && (dq_out == beat_mem[start_column_bits ^ slot]))
        else $error("interleaved beat out of order");

    a_write_pull_in: assert property (
        (state == ST_WR_BURST) && fixed_chop_burst && (slot == 3'h5)
            |=> internal_write_start)
        else $error("fixed chop write not pulled in");

    a_write_otf_timing: assert property (
        (state == ST_WR_BURST) && !fixed_chop_burst && (slot == 3'h5)
            |=> !internal_write_start ##2 internal_write_start)
        else $error("eight beat write start wrong");

    a_self_refresh_loop: assert property (
        self_refresh |-> !loop_running)
        else $error("loop running in self refresh");

    a_slow_exit_freeze: assert property (
        precharge_powerdown && !operating_mode_register[OPM_PD_FAST] |-> !loop_running)
        else $error("loop not frozen in slow exit power-down");

    a_read_latency_wait: assert property (
        take_read && (total_read_delay == 5'h04)
            |-> ##1 (state == ST_RD_WAIT) [*3] ##1 (state == ST_RD_BURST))
        else $error("first read beat at wrong cycle");

    a_sequential_order: assert property (
        (state == ST_RD_BURST) && !interleave && (slot != LAST_SLOT)
            |=> (dq_out == beat_mem[{start_column_bits[2] ^ slot[2],
                                     start_column_bits[1:0] + slot[1:0]}]))
        else $error("sequential beat out of order");

    // Tail slots of a chop carry don't-care data
    a_chop_write_half: assert property (
        (state == ST_WR_BURST) && chop && slot[2] |-> !wr_store)
        else $error("chopped write stored a tail slot");

    c_chop_read:    cover property (take_read && cmd_chop);
    c_interleave:   cover property ((state == ST_RD_BURST) && interleave);
    c_fixed_write:  cover property (take_write && cmd_fixed);
    c_loop_reset:   cover property (wr_opm && addr[OPM_LOOP_RST]);
    c_otf_chop:     cover property (take_write && cmd_chop && !cmd_fixed);
endmodule : dram_mode_config_burst_order
`default_nettype wire

// >>> mode_pkg.sv
// Purpose: Shared constants and types for the mode register bank
// Assumes: Command pins and beat data are sampled on ref_clk
// Notes: One data beat is modelled per ref_clk cycle
package mode_pkg;
    // Bank address codes of the two mode registers, and address width
    localparam logic [2:0] BANK_OPERATING = 3'h0;
    localparam logic [2:0] BANK_LOOP      = 3'h1;
    localparam int         ADDR_W         = 13;

    // Operating mode register field positions
    localparam int OPM_BL_LO    = 0;
    localparam int OPM_BL_HI    = 1;
    localparam int OPM_CL_LOW   = 2;
    localparam int OPM_ORDER    = 3;
    localparam int OPM_CL_HI_LO = 4;
    localparam int OPM_CL_HI_HI = 6;
    localparam int OPM_TEST     = 7;
    localparam int OPM_LOOP_RST = 8;
    localparam int OPM_WR_LO    = 9;
    localparam int OPM_WR_HI    = 11;
    localparam int OPM_PD_FAST  = 12;

    // Loop and drive register field positions
    localparam int LD_LOOP_OFF = 0;
    localparam int LD_DRV_LO   = 1;
    localparam int LD_AL_LO    = 3;
    localparam int LD_AL_HI    = 4;
    localparam int LD_DRV_HI   = 5;
    localparam int LD_OUT_OFF  = 12;

    // Reset values of the mode registers (undefined in silicon, zero here)
    localparam logic [ADDR_W-1:0] OPM_RESET = 13'h0000;
    localparam logic [ADDR_W-1:0] LD_RESET  = 13'h0000;

    // Column read latency: base added to the low and high code groups
    localparam logic [4:0] CL_BASE_LOW  = 5'h04;
    localparam logic [4:0] CL_BASE_HIGH = 5'h0c;

    // Burst length codes
    typedef enum logic [1:0] {
        BL_FIXED_EIGHT = 2'h0,
        BL_ON_THE_FLY  = 2'h1,
        BL_FIXED_CHOP  = 2'h2,
        BL_RESERVED    = 2'h3
    } burst_len_t;

    // Beat slots per burst, and slot of internal write start for eight beats
    localparam logic [2:0] LAST_SLOT      = 3'h7;
    localparam logic [2:0] CHOP_LAST_SLOT = 3'h3;
    localparam logic [2:0] WR_START_EIGHT = 3'h7;
    localparam logic [2:0] WR_PULL_IN     = 3'h2;

    // Loop lock time in clock cycles
    localparam int LOOP_LOCK_CYCLES = 512;
endpackage : mode_pkg

// >>> mode_ctrl_model.sv
// Purpose: Controller model that issues commands to the mode bank
// Assumes: Signals launch just after a ref_clk rising edge
// Notes: Idle bank, address and data lines show inverted values so stale data never matches
`timescale 1ns/10ps
`default_nettype none
module mode_ctrl_model (
    input  wire logic        ref_clk,
    output var  logic        cs_n,
    output var  logic        ras_n,
    output var  logic        cas_n,
    output var  logic        we_n,
    output var  logic [2:0]  bank,
    output var  logic [12:0] addr,
    output var  logic [15:0] dq
);
    initial begin
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        bank = 3'h0;
        addr = 13'h0000;
        dq = 16'h0000;
    end
    task automatic issue(input logic [3:0] cmd, input logic [2:0] ba, input logic [12:0] a);
        @(posedge ref_clk);
        {cs_n, ras_n, cas_n, we_n} <= cmd;
        bank <= ba;
        addr <= a;
        @(posedge ref_clk);
        {cs_n, ras_n, cas_n, we_n} <= 4'hf;
        bank <= ~ba;
        addr <= ~a;
    endtask
    // Test bit forced low
    task automatic mrs_opm(input logic [12:0] a);
        issue(4'h0, 3'h0, a & 13'h1f7f);
    endtask
    // Reserved and termination bits forced low
    task automatic mrs_ld(input logic [12:0] a);
        issue(4'h0, 3'h1, a & 13'h103b);
    endtask
    task automatic rd(input logic [2:0] ca, input logic otf);
        issue(4'h5, 3'h0, {otf, 9'h000, ca});
    endtask
    task automatic wr(input logic [2:0] ca, input logic otf, input logic [15:0] base);
        issue(4'h4, 3'h0, {otf, 9'h000, ca});
        for (int n = 0; n < 8; n++) begin
            if (n > 0) @(posedge ref_clk);
            dq <= base + 16'(n);
        end
        @(posedge ref_clk);
        dq <= ~dq;
    endtask
endmodule // mode_ctrl_model
`default_nettype wire

// >>> dram_mode_config_burst_order_tb_top.sv
// Purpose: Self-checking bench for the mode register bank
// Assumes: LOCK_COUNT shortened to keep the run brief
// Notes: Read expectations use a private copy of the beat store
`timescale 1ns/10ps
`default_nettype none
module dram_mode_config_burst_order_tb_top;
    import mode_pkg::*;
    localparam int LOCK = 8;
    logic ref_clk, rst_n, sref, ppd, dq_oe, strobe_oe, test_mode, run, lock, iws;
    wire logic cs_n, ras_n, cas_n, we_n;
    wire logic [2:0] bank;
    wire logic [12:0] addr;
    wire logic [15:0] dq_in;
    logic [15:0] dq_out, mem [8];
    logic [4:0] cl, rl;
    logic [2:0] wrec;
    logic [1:0] drv;
    int err_total, tests_run, cyc, iws_at;
    mode_ctrl_model ctrl (.ref_clk(ref_clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .bank(bank), .addr(addr), .dq(dq_in));
    dram_mode_config_burst_order #(.DQ_W(16), .LOCK_COUNT(LOCK)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .chip_select_n(cs_n), .row_strobe_n(ras_n),
        .column_strobe_n(cas_n), .write_enable_n(we_n), .bank_addr(bank), .addr(addr),
        .dq_in(dq_in), .self_refresh(sref), .precharge_powerdown(ppd), .dq_out(dq_out),
        .dq_oe(dq_oe), .strobe_oe(strobe_oe), .column_read_latency(cl),
        .total_read_delay(rl), .test_mode(test_mode), .write_recovery(wrec),
        .drive_strength(drv), .loop_running(run), .loop_locking(lock),
        .internal_write_start(iws));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (iws === 1'b1) iws_at <= cyc;
    end
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    function automatic logic [12:0] opm(input logic [1:0] bl, input logic ord,
                                        input logic [3:0] c, input logic [2:0] w, input logic pf);
        return {pf, w, 2'h0, c[2:0], ord, c[3], bl};
    endfunction
    function automatic logic [12:0] ld(input logic off, input logic [1:0] d,
                                       input logic [1:0] al, input logic dis);
        return {dis, 6'h00, d[1], al, 1'b0, d[0], off};
    endfunction
    // Latency 4, no added delay: first beat four cycles after the command
    task automatic rd_chk(input logic [2:0] ca, input logic otf, input logic chop,
                          input logic ilv, input logic on);
        logic [2:0] b;
        logic drive;
        ctrl.rd(ca, otf);
        tick(3);
        for (int i = 0; i < 8; i++) begin
            b = ilv ? ca ^ i[2:0] : {ca[2] ^ i[2], ca[1:0] + i[1:0]};
            drive = on && !(chop && i > 3);
            chk("dq_oe", 16'(dq_oe), 16'(drive));
            chk("strobe_oe", 16'(strobe_oe), 16'(drive));
            if (drive) chk("dq_out", dq_out, mem[b]);
            tick(1);
        end
    endtask
    task automatic wr_chk(input logic [2:0] ca, input logic otf, input logic [15:0] base,
                          input logic chop, input int off);
        int w0;
        ctrl.wr(ca, otf, base);
        #1;
        w0 = cyc;
        for (int i = 0; i < 8; i++) begin
            if (!chop) mem[i] = base + 16'(i);
            else if (i < 4) mem[{ca[2], i[1:0]}] = base + 16'(i);
        end
        tick(2);
        chk("write_start", 16'(iws_at), 16'(w0 + off));
    endtask
    task automatic t_decode();
        logic [3:0] c [4] = '{4'h0, 4'h3, 4'h8, 4'hb};
        logic [4:0] ec [4] = '{5'h04, 5'h07, 5'h0c, 5'h0f};
        logic [4:0] er [4] = '{5'h04, 5'h0d, 5'h16, 5'h0f};
        chk("reset_latency", 16'(cl), 16'h0004);
        for (int i = 0; i < 4; i++) begin
            ctrl.mrs_opm(opm(2'h0, 1'b0, c[i], 3'(i + 1), 1'b0));
            ctrl.mrs_ld(ld(1'b0, i[1:0], i[1:0], 1'b0));
            tick(1);
            chk("latency", 16'(cl), 16'(ec[i]));
            chk("read_delay", 16'(rl), 16'(er[i]));
            chk("recovery", 16'(wrec), 16'(i + 1));
            chk("drive", 16'(drv), 16'(i[1:0]));
            chk("test_mode", 16'(test_mode), 16'h0000);
        end
        ctrl.mrs_ld(ld(1'b0, 2'h0, 2'h0, 1'b0));
    endtask
    task automatic t_loop();
        ctrl.mrs_opm(13'h0100);
        tick(2);
        chk("locking", 16'(lock), 16'h0001);
        tick(LOCK - 2);
        chk("locking", 16'(lock), 16'h0001);
        tick(1);
        chk("locking", 16'(lock), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            ctrl.mrs_opm(opm(2'h0, 1'b0, 4'h0, 3'h1, i[0]));
            @(posedge ref_clk);
            sref <= (i == 3);
            ppd <= (i < 2);
            tick(1);
            chk("loop_running", 16'(run), 16'(i == 1 || i == 2));
        end
        @(posedge ref_clk);
        sref <= 1'b0;
    endtask
    task automatic t_bursts();
        ctrl.mrs_opm(opm(2'h0, 1'b0, 4'h0, 3'h1, 1'b0));
        wr_chk(3'h3, 1'b1, 16'h1000, 1'b0, 0);
        rd_chk(3'h5, 1'b1, 1'b0, 1'b0, 1'b1);
        ctrl.mrs_opm(opm(2'h0, 1'b1, 4'h0, 3'h1, 1'b0));
        rd_chk(3'h5, 1'b1, 1'b0, 1'b1, 1'b1);
        ctrl.mrs_opm(opm(2'h2, 1'b0, 4'h0, 3'h1, 1'b0));
        wr_chk(3'h6, 1'b1, 16'h2000, 1'b1, -2);
        rd_chk(3'h6, 1'b1, 1'b1, 1'b0, 1'b1);
        ctrl.mrs_opm(opm(2'h2, 1'b1, 4'h0, 3'h1, 1'b0));
        rd_chk(3'h7, 1'b1, 1'b1, 1'b1, 1'b1);
        ctrl.mrs_opm(opm(2'h1, 1'b0, 4'h0, 3'h1, 1'b0));
        wr_chk(3'h1, 1'b0, 16'h3000, 1'b1, 0);
        rd_chk(3'h2, 1'b0, 1'b1, 1'b0, 1'b1);
        rd_chk(3'h2, 1'b1, 1'b0, 1'b0, 1'b1);
        ctrl.mrs_ld(ld(1'b0, 2'h0, 2'h0, 1'b1));
        rd_chk(3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    endtask
    initial begin
        {rst_n, sref, ppd, err_total, tests_run, cyc, iws_at} = '0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        tick(1);
        t_decode();
        t_loop();
        t_bursts();
        conclude();
    end
    initial begin
        #300000;
        err_total++;
        conclude();
    end
endmodule // dram_mode_config_burst_order_tb_top
`default_nettype wire
